// ### shared/pmic_mon_map.svh
/*
 * Offsets, field positions, reset values and timing counts of the fault monitor.
 * Assumes a 50 MHz register clock and 32-bit AXI4-Lite words at aligned byte offsets.
 */
`ifndef PMIC_MON_MAP_SVH
`define PMIC_MON_MAP_SVH

// Clock rate and filter times
`define CLK_MHZ        50
`define EN_SYNC_US     3
`define UVLO_RISE_US   3
`define OVP_RISE_US    1
`define OVP_FALL_US    20
`define THERM_US       20
`define PG_US          6
`define OVL_US         1000
`define EN_SYNC_CYC    (`EN_SYNC_US * `CLK_MHZ)
`define UVLO_RISE_CYC  (`UVLO_RISE_US * `CLK_MHZ)
`define OVP_RISE_CYC   (`OVP_RISE_US * `CLK_MHZ)
`define OVP_FALL_CYC   (`OVP_FALL_US * `CLK_MHZ)
`define THERM_CYC      (`THERM_US * `CLK_MHZ)
`define PG_CYC         (`PG_US * `CLK_MHZ)
`define OVL_CYC        (`OVL_US * `CLK_MHZ)
`define FALL_NOW_CYC   1

// Register byte offsets
`define OFS_CTRL       8'h00
`define OFS_GPO        8'h04
`define OFS_FLAGS      8'h08
`define OFS_MASK       8'h0c
`define OFS_STATUS     8'h10

// Control and output register fields
`define CTRL_EN_LSB    0
`define CTRL_PIN_LSB   4
`define CTRL_RDIS_LSB  8
`define CTRL_TWSEL     12
`define CTRL_PSEL      13
`define CTRL_SWRST     16
`define CTRL_WMASK     32'h0000_3fff
`define CTRL_OTP       32'h0000_0f00
`define GPO_OD_LSB     0
`define GPO_LVL_LSB    2
`define GPO_SEQ_LSB    4
`define GPO_OTP        6'h00

// Flag, mask and status fields
`define FLG_TWARN      0
`define FLG_TSD        1
`define FLG_OVP        2
`define FLG_RST        3
`define FLG_SHORT_LSB  4
`define FLG_SUM_LSB    8
`define MASK_OTP       12'h000
`define ST_TWARN       0
`define ST_TSD         1
`define ST_OVP         2
`define ST_SUP         3
`define ST_RUN_LSB     4
`define ST_MODE_LSB    8
`define ST_PG          10

// Bus answers
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ### shared/pmic_mon_pkg.sv
/*
 * Types shared by the fault monitor and its testbench.
 * Assumes the constants of pmic_mon_map.svh are included where needed.
 */
package pmic_mon_pkg;

  // Device modes, Gray coded along shutdown, load, standby, active
  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'h0,
    MODE_OTP      = 2'h1,
    MODE_STANDBY  = 2'h3,
    MODE_ACTIVE   = 2'h2
  } mode_type;

  // Raw comparator and pin levels, all asynchronous to aclk
  typedef struct packed {
    logic       en;
    logic       supply_ok;
    logic       ovp;
    logic       tsd;
    logic [1:0] twarn;
    logic       pg;
  } raw_in_type;

  // One output pin driver
  typedef struct packed {
    logic o;
    logic oe;
  } pin_type;

endpackage

// ### hdl/level_debounce.sv
/*
 * Two-flop synchroniser followed by a counting debounce filter.
 * Assumes raw is asynchronous; each edge must hold its own count of cycles.
 */
module level_debounce #(
  parameter int RISE_CNT = 1,
  parameter int FALL_CNT = 1
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Levels
  input  wire logic raw,
  output logic      live
);

  logic        sync1_reg;
  logic        sync2_reg;
  logic        live_reg;
  logic [15:0] cnt_reg;
  logic [15:0] lim;

  // Synchroniser; first flop feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
    end
  end

  assign lim = sync2_reg ? 16'(RISE_CNT - 1) : 16'(FALL_CNT - 1);

  // Window restarts on any bounce, so accuracy is one clock period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg  <= 16'h0000;
      live_reg <= 1'b0;
    end else if (sync2_reg == live_reg) begin
      cnt_reg <= 16'h0000;
    end else if (cnt_reg >= lim) begin
      cnt_reg  <= 16'h0000;
      live_reg <= sync2_reg;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  assign live = live_reg;

endmodule

// ### hdl/pmic_fault_protection_monitor.sv
/*
 * Fault and protection supervisor of a power-management device with two
 * switching (0,1) and two linear (2,3) regulators, with AXI4-Lite registers.
 * Assumes analog comparators and pins arrive asynchronously and are filtered here.
 */
// Behaviour
// - Rising temperature over selected warning threshold sets warning flag, pulls interrupt low.
// - Warning has live status; write 1 clears flag; mask 1 silences it.
// - Regulator shut off by fault: switches off, discharge only if its bit set.
// - Output still low 1 ms after enable means short; regulator disabled.
// - Output low continuously 1 ms in operation means overload; regulator disabled.
// - Short or overload sets short and summary flags, clears running, interrupts.
// - Write 1 clears short flag; regulator retries if still enabled.
// - Overvoltage: all off at once, discharge, outputs low, flag, interrupt.
// - Overvoltage flag clear ignored while condition persists; live status readable.
// - No regulator enable while overvoltage present or its flag pending.
// - Thermal shutdown: all off, flag, interrupt, standby; clear and enable blocked.
// - Supply below lockout: all off, discharge, shutdown; above it, up to standby.
// - Reset flag set on leaving shutdown or software reset; host writes 1 to clear.
// - Second general output shares its pin with external clock input by select bit.
// - Per output drive-type bit picks push-pull or open-drain; level bit sets level.
// - Sequence-control bit makes output follow the enable pin sequence.
// - Inputs debounced by sampling and counting, one clock of accuracy.
// - Enable pin passes both edges after 3 us synchronisation only.
// - Falling supply acts at once; rising supply takes 3 us synchronisation.
// - Overvoltage must hold 1 us to assert, its removal 20 us to clear.
// - Power-good output and source filtered 6 us on both edges.
// - Load defaults with regulators off, then full access in standby and active.
`include "pmic_mon_map.svh"

module pmic_fault_protection_monitor #(
  parameter int OVL_CYCLES = `OVL_CYC
) (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]             awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  // AXI4-Lite read
  input  wire logic [7:0]             araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  // Asynchronous monitors and pins
  input  wire pmic_mon_pkg::raw_in_type mon_in,
  input  wire logic [3:0]             out_low_in,
  input  wire logic                   shared_pin_in,
  // Regulator power stage
  output logic [3:0]                  reg_on,
  output logic [3:0]                  discharge_on,
  // Device pins and mode
  output pmic_mon_pkg::pin_type       general_output_a,
  output pmic_mon_pkg::pin_type       general_output_b,
  output logic                        ext_sync_clk_sampled,
  output logic                        irq_out_n,
  output logic                        power_good_out,
  output pmic_mon_pkg::mode_type      mode_out
);
  import pmic_mon_pkg::*;

  logic        en_live, supply_live, overvoltage_live, thermal_shutdown_live, pg_live;
  logic [1:0]  twarn_lvl;
  logic        thermal_warning_live, twarn_d_reg;
  logic [31:0] ctrl_reg;
  logic [5:0]  gpo_reg;
  logic [11:0] flag_reg, mask_reg, flag_set, flag_clr;
  mode_type    mode_reg, mode_next;
  logic [3:0]  run_reg, run_next, fault, disch_reg;
  logic        allow, swrst, acc_ok, sh_s1_reg, sh_s2_reg;
  logic        awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [31:0] rdata_reg, wbits;
  logic        wr_go, rd_go, wr_hit, rd_hit, irq_reg, pg_reg, sclk_reg;
  pin_type     gpa_reg, gpb_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  level_debounce #(.RISE_CNT(`EN_SYNC_CYC), .FALL_CNT(`EN_SYNC_CYC)) u_en (
    .aclk(aclk), .aresetn(aresetn), .raw(mon_in.en), .live(en_live));
  level_debounce #(.RISE_CNT(`UVLO_RISE_CYC), .FALL_CNT(`FALL_NOW_CYC)) u_sup (
    .aclk(aclk), .aresetn(aresetn), .raw(mon_in.supply_ok), .live(supply_live));
  level_debounce #(.RISE_CNT(`OVP_RISE_CYC), .FALL_CNT(`OVP_FALL_CYC)) u_ovp (
    .aclk(aclk), .aresetn(aresetn), .raw(mon_in.ovp), .live(overvoltage_live));
  level_debounce #(.RISE_CNT(`THERM_CYC), .FALL_CNT(`THERM_CYC)) u_tsd (
    .aclk(aclk), .aresetn(aresetn), .raw(mon_in.tsd), .live(thermal_shutdown_live));
  level_debounce #(.RISE_CNT(`PG_CYC), .FALL_CNT(`PG_CYC)) u_pg (
    .aclk(aclk), .aresetn(aresetn), .raw(mon_in.pg), .live(pg_live));

  // Both warning thresholds are filtered so a select change takes effect at once
  for (genvar g = 0; g < 2; g++) begin : g_tw
    level_debounce #(.RISE_CNT(`THERM_CYC), .FALL_CNT(`THERM_CYC)) u_tw (
      .aclk(aclk), .aresetn(aresetn), .raw(mon_in.twarn[g]), .live(twarn_lvl[g]));
  end

  assign thermal_warning_live = ctrl_reg[`CTRL_TWSEL] ? twarn_lvl[1] : twarn_lvl[0];

  // Bus handshakes; address and data are taken together
  assign wr_go  = awvalid & wvalid & awready_reg & wready_reg;
  assign rd_go  = arvalid & arready_reg;
  assign wr_hit = (awaddr == `OFS_CTRL) | (awaddr == `OFS_GPO) | (awaddr == `OFS_FLAGS)
                | (awaddr == `OFS_MASK) | (awaddr == `OFS_STATUS);
  assign rd_hit = (araddr == `OFS_CTRL) | (araddr == `OFS_GPO) | (araddr == `OFS_FLAGS)
                | (araddr == `OFS_MASK) | (araddr == `OFS_STATUS);
  // write access only in standby and active; reads are answered in every mode
  assign acc_ok = (mode_reg == MODE_STANDBY) | (mode_reg == MODE_ACTIVE);
  assign wbits  = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}} & wdata;
  assign swrst  = wr_go & acc_ok & (awaddr == `OFS_CTRL) & wbits[`CTRL_SWRST];

  // Write address and data ready, one cycle per accepted pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
    end else begin
      awready_reg <= awvalid & wvalid & ~awready_reg & ~bvalid_reg;
      wready_reg  <= awvalid & wvalid & ~wready_reg & ~bvalid_reg;
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read channel; status is sampled at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      arready_reg <= arvalid & ~arready_reg & ~rvalid_reg;
      if (rd_go) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        case (araddr)
          `OFS_CTRL:   rdata_reg <= ctrl_reg;
          `OFS_GPO:    rdata_reg <= {26'h0, gpo_reg};
          `OFS_FLAGS:  rdata_reg <= {20'h0, flag_reg};
          `OFS_MASK:   rdata_reg <= {20'h0, mask_reg};
          `OFS_STATUS: rdata_reg <= {21'h0, pg_reg, mode_reg, run_reg, supply_live,
                                     overvoltage_live, thermal_shutdown_live, thermal_warning_live};
          default:     rdata_reg <= 32'h0000_0000;
        endcase
      end else if (rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // defaults reload in the load state
  always_ff @(posedge aclk) begin
    if (!aresetn || mode_reg == MODE_OTP) begin
      ctrl_reg <= `CTRL_OTP;
      gpo_reg  <= `GPO_OTP;
      mask_reg <= `MASK_OTP;
    end else if (wr_go && acc_ok) begin
      if (awaddr == `OFS_CTRL) ctrl_reg <= (ctrl_reg & ~`CTRL_WMASK) | (wbits & `CTRL_WMASK);
      if (awaddr == `OFS_GPO) gpo_reg <= wbits[5:0] | (gpo_reg & ~{6{wstrb[0]}});
      if (awaddr == `OFS_MASK) mask_reg <= wbits[11:0] | (mask_reg & ~{{4{wstrb[1]}}, {8{wstrb[0]}}});
    end
  end

  always_comb begin
    case (mode_reg)
      MODE_SHUTDOWN: mode_next = supply_live ? MODE_OTP : MODE_SHUTDOWN;
      MODE_OTP:      mode_next = MODE_STANDBY;
      MODE_STANDBY:  mode_next = (|run_reg) ? MODE_ACTIVE : MODE_STANDBY;
      MODE_ACTIVE:   mode_next = (|run_reg) ? MODE_ACTIVE : MODE_STANDBY;
      default:       mode_next = MODE_SHUTDOWN;
    endcase
    if (!supply_live || swrst) mode_next = MODE_SHUTDOWN;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) mode_reg <= MODE_SHUTDOWN;
    else mode_reg <= mode_next;
  end

  assign allow = acc_ok & ~swrst & supply_live & ~overvoltage_live & ~flag_reg[`FLG_OVP]
               & ~thermal_shutdown_live & ~flag_reg[`FLG_TSD];

  // Per regulator enable and short timer
  for (genvar i = 0; i < 4; i++) begin : g_reg
    logic        low_s1_reg, low_s2_reg, want;
    logic [15:0] ovl_cnt_reg;

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        low_s1_reg <= 1'b0;
        low_s2_reg <= 1'b0;
      end else begin
        low_s1_reg <= out_low_in[i];
        low_s2_reg <= low_s1_reg;
      end
    end

    // low for 1 ms without a break while running, after enable or in operation
    always_ff @(posedge aclk) begin
      if (!aresetn || !run_reg[i] || !low_s2_reg) ovl_cnt_reg <= 16'h0000;
      else ovl_cnt_reg <= ovl_cnt_reg + 16'h0001;
    end
    assign fault[i] = run_reg[i] & low_s2_reg & (ovl_cnt_reg == 16'(OVL_CYCLES - 1));

    assign want = ctrl_reg[`CTRL_EN_LSB + i] & (~ctrl_reg[`CTRL_PIN_LSB + i] | en_live);
    assign run_next[i] = want & allow & ~flag_reg[`FLG_SHORT_LSB + i] & ~fault[i];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) run_reg <= 4'h0;
    else run_reg <= run_next;
  end

  // discharge only if enabled; one process owns the whole vector
  always_ff @(posedge aclk) begin
    if (!aresetn) disch_reg <= 4'h0;
    else disch_reg <= ~run_next & ctrl_reg[`CTRL_RDIS_LSB +: 4];
  end

  // Flag sources; hardware set wins over a same-cycle clear
  always_comb begin
    flag_set = 12'h000;
    flag_set[`FLG_TWARN] = thermal_warning_live & ~twarn_d_reg;
    flag_set[`FLG_TSD] = thermal_shutdown_live;
    flag_set[`FLG_OVP] = overvoltage_live;
    flag_set[`FLG_RST] = (mode_reg == MODE_OTP);
    flag_set[`FLG_SHORT_LSB +: 4] = fault;
    flag_set[`FLG_SUM_LSB +: 4] = fault;
    flag_clr = 12'h000;
    if (wr_go && acc_ok && awaddr == `OFS_FLAGS) flag_clr = wbits[11:0];
    if (overvoltage_live) flag_clr[`FLG_OVP] = 1'b0;
    if (thermal_shutdown_live) flag_clr[`FLG_TSD] = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || mode_reg == MODE_SHUTDOWN) flag_reg <= 12'h000;
    else flag_reg <= (flag_reg & ~flag_clr) | flag_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) twarn_d_reg <= 1'b0;
    else twarn_d_reg <= thermal_warning_live;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) irq_reg <= 1'b1;
    else irq_reg <= ~|(flag_reg & ~mask_reg);
  end

  // power-good gated by pending supply and thermal faults
  always_ff @(posedge aclk) begin
    if (!aresetn) pg_reg <= 1'b0;
    else pg_reg <= pg_live & ~flag_reg[`FLG_OVP] & ~flag_reg[`FLG_TSD] & acc_ok;
  end

  function automatic pin_type drive(input logic od, input logic lvl);
    drive.o  = od ? 1'b0 : lvl;
    drive.oe = od ? ~lvl : 1'b1;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpa_reg <= '{o: 1'b0, oe: 1'b0};
      gpb_reg <= '{o: 1'b0, oe: 1'b0};
    end else begin
      gpa_reg <= drive(gpo_reg[`GPO_OD_LSB], gpo_reg[`GPO_LVL_LSB] & acc_ok & ~overvoltage_live
                       & (~gpo_reg[`GPO_SEQ_LSB] | en_live));
      // shared pin released in clock mode
      if (ctrl_reg[`CTRL_PSEL]) gpb_reg <= '{o: 1'b0, oe: 1'b0};
      else gpb_reg <= drive(gpo_reg[`GPO_OD_LSB + 1], gpo_reg[`GPO_LVL_LSB + 1] & acc_ok
                            & ~overvoltage_live & (~gpo_reg[`GPO_SEQ_LSB + 1] | en_live));
    end
  end

  // sampled clock input; only slow clocks survive sampling at 50 MHz
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_s1_reg <= 1'b0;
      sh_s2_reg <= 1'b0;
      sclk_reg  <= 1'b0;
    end else begin
      sh_s1_reg <= shared_pin_in;
      sh_s2_reg <= sh_s1_reg;
      sclk_reg  <= sh_s2_reg & ctrl_reg[`CTRL_PSEL];
    end
  end

  // Port drive, all from flops
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;
  assign reg_on = run_reg;
  assign discharge_on = disch_reg;
  assign general_output_a = gpa_reg;
  assign general_output_b = gpb_reg;
  assign ext_sync_clk_sampled = sclk_reg;
  assign irq_out_n = irq_reg;
  assign power_good_out = pg_reg;
  assign mode_out = mode_reg;

  property p_irq;
    (|(flag_reg & ~mask_reg)) |=> !irq_out_n;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not low with unmasked flag");

  property p_twarn;
    $rose(thermal_warning_live) && mode_reg != MODE_SHUTDOWN |=> flag_reg[`FLG_TWARN];
  endproperty
  a_twarn: assert property (p_twarn) else $error("warning flag not set");

  property p_ovp_off;
    overvoltage_live |=> reg_on == 4'h0 && !general_output_a.o;
  endproperty
  a_ovp_off: assert property (p_ovp_off) else $error("overvoltage left output on");

  property p_ovp_hold;
    overvoltage_live && flag_reg[`FLG_OVP] |=> flag_reg[`FLG_OVP];
  endproperty
  a_ovp_hold: assert property (p_ovp_hold) else $error("overvoltage flag cleared early");

  property p_block;
    flag_reg[`FLG_OVP] || flag_reg[`FLG_TSD] |=> reg_on == 4'h0;
  endproperty
  a_block: assert property (p_block) else $error("regulator on while fault pends");

  property p_short;
    fault[0] |=> flag_reg[`FLG_SHORT_LSB] && flag_reg[`FLG_SUM_LSB] && !reg_on[0] ##1 !irq_out_n
      || mask_reg[`FLG_SHORT_LSB];
  endproperty
  a_short: assert property (p_short) else $error("short not flagged");

  property p_uvlo;
    !supply_live |=> mode_out == MODE_SHUTDOWN && reg_on == 4'h0;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("lockout ignored");

  property p_rst;
    mode_reg == MODE_OTP && supply_live |=> flag_reg[`FLG_RST] && mode_reg == MODE_STANDBY;
  endproperty
  a_rst: assert property (p_rst) else $error("reset flag missing");

  property p_tsd;
    thermal_shutdown_live |=> reg_on == 4'h0 ##1 mode_out != MODE_ACTIVE;
  endproperty
  a_tsd: assert property (p_tsd) else $error("thermal shutdown ignored");

endmodule

// ### dv/irq_watch.sv
/*
 * Host side of the interrupt pin: counts each new service request.
 * Assumes the pin is a registered level in the aclk domain.
 */
module irq_watch (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Pin and tally
  input  wire logic irq_out_n,
  output int        irq_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_reg;

  // A fall is one request; the level alone would count a held pin many times
  always_ff @(posedge aclk) begin
    last_reg <= irq_out_n;
    if (!aresetn) irq_count <= 0;
    else if (last_reg && !irq_out_n) irq_count <= irq_count + 1;
  end
endmodule

// ### dv/tb.sv
/*
 * Testbench of the fault monitor: bus tasks, fault stimulus and compares.
 * Assumes the map header on the include path and a short overload count.
 */
`include "pmic_mon_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pmic_mon_pkg::*;
  localparam int OVL = 20;
  logic       aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic       awready, wready, bvalid, arready, rvalid, sp_in, sync_clk, irq_n, pg_out;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb, out_low, reg_on, dis_on;
  logic [1:0] bresp, rresp, r;
  raw_in_type mon;
  pin_type    gpo_a, gpo_b;
  mode_type   mode;
  int         fails, num_checks, irq_count;

  // Clock at 50 MHz
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  pmic_fault_protection_monitor #(.OVL_CYCLES(OVL)) DUT (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .mon_in(mon), .out_low_in(out_low), .shared_pin_in(sp_in),
    .reg_on(reg_on), .discharge_on(dis_on), .general_output_a(gpo_a), .general_output_b(gpo_b),
    .ext_sync_clk_sampled(sync_clk), .irq_out_n(irq_n), .power_good_out(pg_out), .mode_out(mode));

  irq_watch host (.aclk(aclk), .aresetn(aresetn), .irq_out_n(irq_n), .irq_count(irq_count));

  // Compare one value and tally it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Write: both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      aw_d |= awready;
      w_d |= wready;
      if (aw_d) awvalid <= 1'b0;
      if (w_d) wvalid <= 1'b0;
    end while (!(aw_d && w_d));
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  // Read: data and response taken at the rvalid edge
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    summarize();
  end

  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, sp_in, aresetn} = '0;
    {awaddr, araddr, wdata, out_low} = '0;
    wstrb = 4'hf;
    mon = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    mon.supply_ok <= 1'b1;
    for (int i = 0; i < 400 && mode !== MODE_STANDBY; i++) @(posedge aclk);
    chk(32'(mode), 32'(MODE_STANDBY));
    rd(`OFS_FLAGS);
    chk(v, 32'h8);
    chk(32'(irq_n), 32'h0);
    rd(`OFS_CTRL);
    chk(v, `CTRL_OTP);
    wr(`OFS_FLAGS, 32'h8);
    chk(32'(irq_n), 32'h1);
    rd(8'h40);
    chk({v[29:0], r}, {30'h0, `RESP_SLVERR});
    // Overload while running, then a retry into a held short
    wr(`OFS_CTRL, 32'h0f01);
    cyc(3);
    chk(32'(reg_on), 32'h1);
    chk(32'(dis_on), 32'he);
    out_low <= 4'h1;
    cyc(OVL + 10);
    chk(32'(reg_on), 32'h0);
    chk(32'(dis_on), 32'hf);
    rd(`OFS_FLAGS);
    chk(v, 32'h110);
    rd(`OFS_STATUS);
    chk(32'(v[7:4]), 32'h0);
    wr(`OFS_FLAGS, 32'h111);
    chk(32'(reg_on), 32'h1);
    cyc(OVL + 10);
    chk(32'(reg_on), 32'h0);
    out_low <= 4'h0;
    wr(`OFS_FLAGS, 32'h111);
    cyc(3);
    chk(32'(reg_on), 32'h1);
    // Output drive types, then overvoltage
    wr(`OFS_GPO, 32'h0c);
    chk({30'h0, gpo_a}, 32'h3);
    wr(`OFS_GPO, 32'h0d);
    chk(32'(gpo_a.oe), 32'h0);
    mon.ovp <= 1'b1;
    cyc(60);
    chk(32'(reg_on), 32'h0);
    chk({30'h0, gpo_b}, 32'h1);
    wr(`OFS_FLAGS, 32'h4);
    rd(`OFS_FLAGS);
    chk(32'(v[2]), 32'h1);
    rd(`OFS_STATUS);
    chk(32'(v[2]), 32'h1);
    mon.ovp <= 1'b0;
    cyc(1060);
    chk(32'(reg_on), 32'h0);
    wr(`OFS_FLAGS, 32'h4);
    cyc(3);
    chk(32'(reg_on), 32'h1);
    wr(`OFS_CTRL, 32'h0f23);
    chk(32'(reg_on), 32'h1);
    mon.en <= 1'b1;
    cyc(160);
    chk(32'(reg_on), 32'h3);
    wr(`OFS_CTRL, 32'h2f01);
    chk(32'(gpo_b.oe), 32'h0);
    sp_in <= 1'b1;
    cyc(4);
    chk(32'(sync_clk), 32'h1);
    // Thermal warning, masked, then thermal shutdown
    mon.twarn <= 2'b01;
    mon.pg <= 1'b1;
    cyc(1060);
    rd(`OFS_FLAGS);
    chk(32'(v[0]), 32'h1);
    wr(`OFS_MASK, 32'h1);
    cyc(2);
    chk(32'(irq_n), 32'h1);
    chk(32'(pg_out), 32'h1);
    mon.tsd <= 1'b1;
    cyc(1060);
    chk(32'(reg_on), 32'h0);
    chk(32'(mode), 32'(MODE_STANDBY));
    chk(32'(pg_out), 32'h0);
    chk(32'(irq_count), 32'h6);
    wr(`OFS_CTRL, 32'h1_0000);
    rd(`OFS_FLAGS);
    chk(v, 32'ha);
    summarize();
  end
endmodule
